// ==== core/mahf_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the address filter.
// Assumes inclusion by its bare name from the filter module and the bench.
`ifndef MAHF_DEFS_SVH
`define MAHF_DEFS_SVH
`define MAHF_OFS_CTRL      12'h100
`define MAHF_OFS_STA_HI    12'h104
`define MAHF_OFS_STA_LO    12'h108
`define MAHF_OFS_HASH_HI   12'h10c
`define MAHF_OFS_HASH_LO   12'h110
`define MAHF_OFS_IRQ_STAT  12'h120
`define MAHF_OFS_IRQ_EN    12'h124
`define MAHF_OFS_IRQ_CLR   12'h128
`define MAHF_BIT_DEFER_CHK 5
`define MAHF_BIT_TX_EN     3
`define MAHF_BIT_RX_EN     2
`define MAHF_BIT_PASS_MC   1
`define MAHF_RST_STA_HI    16'hffff
`define MAHF_RST_STA_LO    32'hffffffff
`define MAHF_RST_HASH      32'h00000000
`define MAHF_DEFER_BITS    24288
`define MAHF_IRQ_DEFER     0
`define MAHF_IRQ_MC_DROP   1
`define MAHF_IRQ_ACCEPT    2
`define MAHF_CRC_POLY      32'hedb88320
`endif

// ==== core/mahf_pkg.sv ====
// Types shared by the address filter.
// Uses nothing from the defines header.
package mahf_pkg;
  typedef enum logic [1:0] {
    MAHF_RX_IDLE,
    MAHF_RX_ADDR,
    MAHF_RX_BODY
  } mahf_rx_state_t;
endpackage

// ==== core/mahf_filter.sv ====
// Receive address filter, enable bits and deferral check of the MAC, with AXI4-Lite registers.
// Assumes a byte stream from the PHY side with frame start marking the first destination octet.
`timescale 1ns/1ps
`include "mahf_defs.svh"
module mahf_filter
  import mahf_pkg::*;
#(
  parameter int BIT_CYCLES   = 1,
  parameter int DEFER_CYCLES = `MAHF_DEFER_BITS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        rst_protect_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_sof_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_eof_i,
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o,
  output logic             rx_eof_o,
  output logic             rx_accept_o,
  output logic             rx_reject_o,
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  output logic             tx_ready_o,
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        tx_pending_i,
  input  wire logic        carrier_sense_i,
  output logic             irq_o
);

  logic [15:0]    station_address_high_r;
  logic [31:0]    station_address_low_r;
  logic [31:0]    multicast_table_upper_r, multicast_table_lower_r;
  logic           receive_enable_r, tx_enable_r;
  logic           defer_check_r, pass_all_multicast_r;
  logic [2:0]     irq_stat_r, irq_en_r;
  logic [2:0]     irq_set, irq_clr;
  logic           aw_held_r, w_held_r;
  logic [11:0]    awaddr_r;
  logic [31:0]    wdata_r;
  logic [3:0]     wstrb_r;
  logic           wr_fire, wr_hit;
  logic [31:0]    rd_word;
  logic           rd_hit;
  mahf_rx_state_t rx_state_r;
  logic [2:0]     oct_cnt_r;
  logic           addr_match_r, multicast_r;
  logic [31:0]    crc_r;
  logic           frame_pass_r;
  logic [7:0]     rx_byte;
  logic [31:0]    crc_nxt;
  logic [5:0]     hash_idx;
  logic           hash_bit, last_addr_oct;
  logic [7:0]     own_octet;
  logic           match_nxt;
  logic [31:0]    defer_cnt_r, bit_cnt_r;
  logic           bit_tick, defer_hit_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? `MAHF_CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  // Write address and data may arrive in either order; each is held until both are present.
  assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_r && !s_axi_bvalid_o;
  assign wr_fire         = aw_held_r && w_held_r && !s_axi_bvalid_o;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata_i;
        wstrb_r  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case ({awaddr_r[11:2], 2'b00})
      `MAHF_OFS_CTRL, `MAHF_OFS_STA_HI, `MAHF_OFS_STA_LO, `MAHF_OFS_HASH_HI,
      `MAHF_OFS_HASH_LO, `MAHF_OFS_IRQ_EN, `MAHF_OFS_IRQ_CLR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Station address survives a reset while protection is asserted.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i && !rst_protect_i) begin
      station_address_high_r <= `MAHF_RST_STA_HI;
      station_address_low_r  <= `MAHF_RST_STA_LO;
    end else if (!reset_i && wr_fire) begin
      if ({awaddr_r[11:2], 2'b00} == `MAHF_OFS_STA_HI) begin
        station_address_high_r <= 16'(merge({16'h0000, station_address_high_r},
                                            wdata_r, wstrb_r));
      end
      if ({awaddr_r[11:2], 2'b00} == `MAHF_OFS_STA_LO) begin
        station_address_low_r <= merge(station_address_low_r, wdata_r, wstrb_r);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      multicast_table_upper_r <= `MAHF_RST_HASH;
      multicast_table_lower_r <= `MAHF_RST_HASH;
      receive_enable_r        <= 1'b0;
      tx_enable_r             <= 1'b0;
      defer_check_r           <= 1'b0;
      pass_all_multicast_r    <= 1'b0;
      irq_en_r                <= 3'h0;
    end else if (wr_fire) begin
      unique case ({awaddr_r[11:2], 2'b00})
        `MAHF_OFS_HASH_HI: multicast_table_upper_r <= merge(multicast_table_upper_r,
                                                            wdata_r, wstrb_r);
        `MAHF_OFS_HASH_LO: multicast_table_lower_r <= merge(multicast_table_lower_r,
                                                            wdata_r, wstrb_r);
        `MAHF_OFS_CTRL: begin
          if (wstrb_r[0]) begin
            receive_enable_r     <= wdata_r[`MAHF_BIT_RX_EN];
            tx_enable_r          <= wdata_r[`MAHF_BIT_TX_EN];
            defer_check_r        <= wdata_r[`MAHF_BIT_DEFER_CHK];
            pass_all_multicast_r <= wdata_r[`MAHF_BIT_PASS_MC];
          end
        end
        `MAHF_OFS_IRQ_EN: begin
          if (wstrb_r[0]) begin
            irq_en_r <= wdata_r[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  assign irq_clr = (wr_fire && wstrb_r[0] && {awaddr_r[11:2], 2'b00} == `MAHF_OFS_IRQ_CLR)
                   ? wdata_r[2:0] : 3'h0;

  // A new event in the cycle of its clear keeps the bit set.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(irq_stat_r & irq_en_r);

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    unique case ({s_axi_araddr_i[11:2], 2'b00})
      `MAHF_OFS_CTRL: begin
        rd_word[`MAHF_BIT_RX_EN]     = receive_enable_r;
        rd_word[`MAHF_BIT_TX_EN]     = tx_enable_r;
        rd_word[`MAHF_BIT_DEFER_CHK] = defer_check_r;
        rd_word[`MAHF_BIT_PASS_MC]   = pass_all_multicast_r;
      end
      `MAHF_OFS_STA_HI:   rd_word = {16'h0000, station_address_high_r};
      `MAHF_OFS_STA_LO:   rd_word = station_address_low_r;
      `MAHF_OFS_HASH_HI:  rd_word = multicast_table_upper_r;
      `MAHF_OFS_HASH_LO:  rd_word = multicast_table_lower_r;
      `MAHF_OFS_IRQ_STAT: rd_word = {29'h00000000, irq_stat_r};
      `MAHF_OFS_IRQ_EN:   rd_word = {29'h00000000, irq_en_r};
      `MAHF_OFS_IRQ_CLR:  rd_word = 32'h00000000;
      default:            rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h00000000;
      s_axi_rresp_o  <= 2'b00;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_word;
      s_axi_rresp_o  <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // Receive side: octet n of the destination address is compared with its register byte.
  // A frame start always compares with the first octet, whatever the last frame left.
  assign rx_byte = rx_data_i;
  always_comb begin
    unique case (rx_sof_i ? 3'd0 : oct_cnt_r)
      3'd0: own_octet = station_address_low_r[7:0];
      3'd1: own_octet = station_address_low_r[15:8];
      3'd2: own_octet = station_address_low_r[23:16];
      3'd3: own_octet = station_address_low_r[31:24];
      3'd4: own_octet = station_address_high_r[7:0];
      default: own_octet = station_address_high_r[15:8];
    endcase
  end

  assign crc_nxt       = crc_byte((rx_sof_i ? 32'hffffffff : crc_r), rx_byte);
  assign last_addr_oct = (oct_cnt_r == 3'd5);
  assign match_nxt     = (rx_sof_i ? 1'b1 : addr_match_r) && (rx_byte == own_octet);
  // Index from the top six bits of the final, complemented CRC of the destination address.
  assign hash_idx      = ~{crc_nxt[26], crc_nxt[27], crc_nxt[28],
                           crc_nxt[29], crc_nxt[30], crc_nxt[31]};
  assign hash_bit      = hash_idx[5] ? multicast_table_upper_r[hash_idx[4:0]]
                                     : multicast_table_lower_r[hash_idx[4:0]];

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_state_r   <= MAHF_RX_IDLE;
      oct_cnt_r    <= 3'd0;
      addr_match_r <= 1'b0;
      multicast_r  <= 1'b0;
      crc_r        <= 32'hffffffff;
      frame_pass_r <= 1'b0;
    end else if (rx_valid_i) begin
      unique case (rx_state_r)
        MAHF_RX_IDLE, MAHF_RX_BODY: begin
          if (rx_sof_i && receive_enable_r) begin
            rx_state_r   <= MAHF_RX_ADDR;
            oct_cnt_r    <= 3'd1;
            crc_r        <= crc_nxt;
            addr_match_r <= match_nxt;
            multicast_r  <= rx_byte[0];
            frame_pass_r <= 1'b0;
          end else if (rx_eof_i) begin
            rx_state_r   <= MAHF_RX_IDLE;
            frame_pass_r <= 1'b0;
          end
        end
        MAHF_RX_ADDR: begin
          crc_r        <= crc_nxt;
          addr_match_r <= match_nxt;
          oct_cnt_r    <= oct_cnt_r + 3'd1;
          if (last_addr_oct) begin
            rx_state_r   <= rx_eof_i ? MAHF_RX_IDLE : MAHF_RX_BODY;
            frame_pass_r <= !rx_eof_i && (match_nxt ||
                            (multicast_r && (pass_all_multicast_r || hash_bit)));
          end else if (rx_eof_i) begin
            rx_state_r <= MAHF_RX_IDLE;
          end
        end
      endcase
    end
  end

  wire decide = rx_valid_i && rx_state_r == MAHF_RX_ADDR && last_addr_oct;
  wire passed = match_nxt || (multicast_r && (pass_all_multicast_r || hash_bit));

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_valid_o  <= 1'b0;
      rx_data_o   <= 8'h00;
      rx_eof_o    <= 1'b0;
      rx_accept_o <= 1'b0;
      rx_reject_o <= 1'b0;
    end else begin
      rx_valid_o  <= rx_valid_i && rx_state_r == MAHF_RX_BODY && frame_pass_r
                     && receive_enable_r;
      rx_data_o   <= rx_data_i;
      rx_eof_o    <= rx_valid_i && rx_eof_i && rx_state_r == MAHF_RX_BODY && frame_pass_r;
      rx_accept_o <= decide && passed;
      rx_reject_o <= decide && !passed;
    end
  end

  assign irq_set[`MAHF_IRQ_ACCEPT]  = decide && passed;
  assign irq_set[`MAHF_IRQ_MC_DROP] = decide && multicast_r && !passed;
  assign irq_set[`MAHF_IRQ_DEFER]   = defer_hit_r;

  // Transmit side passes bytes only while enabled.
  assign tx_ready_o = tx_enable_r && tx_ready_i;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
    end else begin
      tx_valid_o <= tx_enable_r && tx_valid_i && tx_ready_i;
      tx_data_o  <= tx_data_i;
    end
  end

  // Bit-time enable pulse and deferral counter.
  assign bit_tick = (bit_cnt_r == 32'(BIT_CYCLES - 1));
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || bit_tick) begin
      bit_cnt_r <= 32'h00000000;
    end else begin
      bit_cnt_r <= bit_cnt_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !(defer_check_r && tx_pending_i && carrier_sense_i)) begin
      defer_cnt_r <= 32'h00000000;
      defer_hit_r <= 1'b0;
    end else begin
      defer_hit_r <= 1'b0;
      if (bit_tick && defer_cnt_r <= 32'(DEFER_CYCLES)) begin
        defer_cnt_r <= defer_cnt_r + 32'h00000001;
        defer_hit_r <= (defer_cnt_r == 32'(DEFER_CYCLES));
      end
    end
  end

endmodule

// ==== test/mahf_filter_sva.sv ====
// Concurrent checks on the ports of the address filter.
// Assumes it is bound to every mahf_filter instance and sees only its ports.
`timescale 1ns/1ps
module mahf_filter_sva (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rready_i,
  input wire logic        rx_valid_i,
  input wire logic        rx_accept_o,
  input wire logic        rx_reject_o,
  input wire logic        tx_valid_i,
  input wire logic [7:0]  tx_data_i,
  input wire logic        tx_ready_i,
  input wire logic        tx_ready_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_tx_taken;
    tx_valid_i && tx_ready_o;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> ##[0:1] s_axi_bvalid_o)
    else $error("write response missing");
  a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");
  a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  a_tx_gate: assert property (tx_ready_o |-> tx_ready_i)
    else $error("tx ready without sink ready");
  a_tx_forward: assert property (s_tx_taken |=> tx_valid_o && tx_data_o == $past(tx_data_i))
    else $error("tx byte not forwarded");
  a_tx_quiet: assert property (tx_valid_o |-> $past(tx_valid_i && tx_ready_o))
    else $error("tx byte from nowhere");
  a_decide_once: assert property (rx_accept_o || rx_reject_o |=> !(rx_accept_o || rx_reject_o))
    else $error("decision longer than one cycle");
  a_decide_excl: assert property (!(rx_accept_o && rx_reject_o))
    else $error("accept and reject together");
  a_decide_cause: assert property (rx_accept_o || rx_reject_o |-> $past(rx_valid_i))
    else $error("decision without address octet");
endmodule
bind mahf_filter mahf_filter_sva chk (.clk_sys_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bresp_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rdata_o, .s_axi_rready_i,
  .rx_valid_i, .rx_accept_o, .rx_reject_o, .tx_valid_i, .tx_data_i, .tx_ready_i, .tx_ready_o,
  .tx_valid_o, .tx_data_o);

// ==== test/mahf_phy_model.sv ====
// Behavioural model of the internal PHY frame paths.
// Assumes the bench calls send to start each received frame.
`timescale 1ns/1ps
module mahf_phy_model (
  input  wire logic       clk_sys_i,
  output logic            rx_valid_o,
  output logic            rx_sof_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_eof_o,
  output logic            tx_ready_o
);
  initial begin
    rx_valid_o = 0;
    rx_sof_o = 0;
    rx_data_o = 8'h5a;
    rx_eof_o = 0;
    tx_ready_o = 0;
  end
  // The transmit sink stalls at random, so both prompt and slow takes occur.
  always @(posedge clk_sys_i) tx_ready_o <= 1'($urandom());
  task automatic send(input logic [47:0] da, input int n_body);
    for (int i = 0; i < 6 + n_body; i++) begin
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b1;
      rx_sof_o <= (i == 0);
      rx_eof_o <= (i == 5 + n_body);
      rx_data_o <= (i < 6) ? da[8*i +: 8] : 8'(i);
    end
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b0;
    rx_sof_o <= 1'b0;
    rx_eof_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
endmodule

// ==== test/mahf_filter_bench.sv ====
// Self-checking bench of the address filter against a register and frame model.
// Assumes the filter, its checker and the PHY model are compiled before it.
`timescale 1ns/1ps
`include "mahf_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module mahf_filter_bench;
  logic        clk_sys_i = 0, reset_i = 1, rst_protect = 0, awvalid = 0, wvalid = 0;
  logic        bready = 0, arvalid = 0, rready = 0, txv = 0, pend = 0, crs = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_d;
  logic [7:0]  txd = 0, rxd, rxo_d, txd_o;
  logic [1:0]  bresp, rresp, rd_r, wr_r;
  logic [47:0] sta, mc;
  logic [63:0] t;
  logic        awready, wready, bvalid, arready, rvalid, rxv, rxs, rxe, rxo_v, rxo_e;
  logic        acc, rej, txr_o, txv_o, txr_i, irq, e;
  logic [31:0] mdl [int];
  bit          exp_q [$];
  int          n_errors = 0, num_checks = 0;
  int          n_body = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  mahf_filter #(.BIT_CYCLES(1), .DEFER_CYCLES(20)) uut (.clk_sys_i, .reset_i,
    .rst_protect_i(rst_protect), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .rx_valid_i(rxv), .rx_sof_i(rxs), .rx_data_i(rxd), .rx_eof_i(rxe), .rx_valid_o(rxo_v),
    .rx_data_o(rxo_d), .rx_eof_o(rxo_e), .rx_accept_o(acc), .rx_reject_o(rej),
    .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr_o), .tx_valid_o(txv_o),
    .tx_data_o(txd_o), .tx_ready_i(txr_i), .tx_pending_i(pend), .carrier_sense_i(crs),
    .irq_o(irq));
  mahf_phy_model phy (.clk_sys_i, .rx_valid_o(rxv), .rx_sof_o(rxs), .rx_data_o(rxd),
    .rx_eof_o(rxe), .tx_ready_o(txr_i));
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    wr_r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 0;
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] v);
    wr(a, v);
    `CHK("write resp", 2'b00, wr_r)
    mdl[a] = (a == `MAHF_OFS_STA_HI) ? (v & 32'h0000ffff) : v;
  endtask
  task automatic rchk(input logic [11:0] a);
    rd(a);
    `CHK("read data", mdl[a], rd_d)
    `CHK("read resp", 2'b00, rd_r)
  endtask
  task automatic frame(input logic [47:0] da, input int ex);
    if (ex < 2) exp_q.push_back(ex[0]);
    n_body = 0;
    phy.send(da, 3);
    repeat (3) @(posedge clk_sys_i);
    `CHK("rx body count", (ex == 1) ? 3 : 0, n_body)
  endtask
  task automatic tx_run(input logic en);
    repeat (16) begin
      @(posedge clk_sys_i);
      txv <= 1'($urandom());
      txd <= 8'($urandom());
      @(negedge clk_sys_i);
      `CHK("tx ready", en & txr_i, txr_o)
    end
  endtask
  // Hash index: complemented reflected CRC of the six octets, bits 26 to 31, bit 26 on top.
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 48; i++) c = (c >> 1) ^ ((c[0] ^ da[i]) ? 32'hedb88320 : 32'h0);
    c = ~c;
    return {c[26], c[27], c[28], c[29], c[30], c[31]};
  endfunction
  always @(posedge clk_sys_i) begin
    if (!reset_i && (acc || rej)) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : !acc;
      `CHK("rx decision", e, acc)
    end
    if (!reset_i && rxo_v) begin
      n_body++;
      `CHK("rx body byte", 8'(5 + n_body), rxo_d)
      `CHK("rx body end", (n_body == 3), rxo_e)
    end
  end
  initial begin
    #400000;
    n_errors++;
    $display("[ERR] watchdog expected done seen hang");
    end_of_test;
  end
  initial begin
    void'($urandom(15300));
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 0;
    mdl[`MAHF_OFS_CTRL] = 0;
    mdl[`MAHF_OFS_STA_HI] = 32'h0000ffff;
    mdl[`MAHF_OFS_STA_LO] = 32'hffffffff;
    mdl[`MAHF_OFS_HASH_HI] = 0;
    mdl[`MAHF_OFS_HASH_LO] = 0;
    foreach (mdl[a]) rchk(12'(a));
    rd(12'h0fc);
    `CHK("unmapped resp", 2'b10, rd_r)
    foreach (mdl[a]) if (a != `MAHF_OFS_CTRL) begin
      wreg(12'(a), $urandom());
      rchk(12'(a));
    end
    $display("test registers done");
    sta = 48'({$urandom(), $urandom()}) & ~48'h1;
    mc = 48'({$urandom(), $urandom()}) | 48'h1;
    wreg(`MAHF_OFS_STA_LO, sta[31:0]);
    wreg(`MAHF_OFS_STA_HI, {16'h0000, sta[47:32]});
    wreg(`MAHF_OFS_CTRL, 32'h0000000c);
    frame(sta, 1);
    frame(sta ^ (48'h1 << 40), 0);
    frame(sta ^ 48'h2, 0);
    for (int k = 0; k < 4; k++) begin
      t = (k == 1) ? (64'h1 << hidx(mc)) : (k == 2) ? ~(64'h1 << hidx(mc)) : 64'h0;
      wreg(`MAHF_OFS_HASH_HI, t[63:32]);
      wreg(`MAHF_OFS_HASH_LO, t[31:0]);
      wreg(`MAHF_OFS_CTRL, (k == 3) ? 32'h0000000e : 32'h0000000c);
      frame(mc, (k == 1 || k == 3));
    end
    wreg(`MAHF_OFS_CTRL, 32'h00000008);
    frame(sta, 2);
    `CHK("pending decisions", 0, exp_q.size())
    $display("test filter done");
    tx_run(1'b1);
    wreg(`MAHF_OFS_CTRL, 32'h0);
    tx_run(1'b0);
    $display("test transmit done");
    wr(`MAHF_OFS_IRQ_CLR, 32'h7);
    wr(`MAHF_OFS_IRQ_EN, 32'h1);
    for (int k = 0; k < 3; k++) begin
      wreg(`MAHF_OFS_CTRL, (k > 0) ? 32'h00000020 : 32'h0);
      pend <= 1;
      crs <= 1;
      repeat ((k == 1) ? 15 : 30) @(posedge clk_sys_i);
      pend <= 0;
      crs <= 0;
      rd(`MAHF_OFS_IRQ_STAT);
      `CHK("defer status", (k == 2), rd_d[0])
      `CHK("irq line", (k == 2), irq)
    end
    wr(`MAHF_OFS_IRQ_EN, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    wr(`MAHF_OFS_IRQ_CLR, 32'h1);
    rd(`MAHF_OFS_IRQ_STAT);
    `CHK("status cleared", 1'b0, rd_d[0])
    $display("test deferral done");
    for (int p = 1; p >= 0; p--) begin
      rst_protect <= p[0];
      reset_i <= 1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 0;
      rst_protect <= 0;
      if (p == 0) begin
        mdl[`MAHF_OFS_STA_HI] = 32'h0000ffff;
        mdl[`MAHF_OFS_STA_LO] = 32'hffffffff;
      end
      mdl[`MAHF_OFS_CTRL] = 0;
      mdl[`MAHF_OFS_HASH_HI] = 0;
      mdl[`MAHF_OFS_HASH_LO] = 0;
      foreach (mdl[a]) rchk(12'(a));
    end
    $display("test reset protection done");
    end_of_test;
  end
endmodule
